// ===== design/abc_cfg.svh
// Offsets, field positions and reset values for the analog control register bank
`ifndef ABC_CFG_SVH
`define ABC_CFG_SVH
`define ADDR_ANALOG_CTRL 4'h0
`define ADDR_SYNC_MODE 4'h1
`define RST_ANALOG_CTRL 8'h00
`define RST_SYNC_MODE 8'h00
`define BIT_DIG_OE 7
`define BIT_DSEL_HI 6
`define BIT_DSEL_LO 4
`define BIT_LOCKOUT 3
`define BIT_VAMP_DIS 2
`define BIT_IAMP_DIS 1
`define BIT_ANA_OE 0
`define BIT_MODE_HI 7
`define BIT_MODE_LO 6
`define BIT_SEMI_OPT 3
`define SYNC_MODE_MASK 8'hc8
`endif

// ===== design/abc_pkg.sv
// Types for the analog control register bank
package abc_pkg;
    typedef enum logic [1:0] {
        MODE_STANDALONE = 2'h0,
        MODE_MASTER = 2'h1,
        MODE_SLAVE = 2'h2,
        MODE_SEMI = 2'h3
    } sync_mode_t;

    typedef struct packed {
        logic voltage_amp_on;
        logic current_amp_on;
        logic voltage_in_control;
        logic current_in_control;
        logic amps_forced_low;
        logic ov_protect_on;
        logic lockout_high;
    } amp_ctrl_t;

    typedef struct packed {
        logic reference_out_en;
        logic sync_out_en;
        logic sync_in_use;
        logic internal_clock;
    } pin_route_t;
endpackage : abc_pkg

// ===== design/analog_block_and_sync_mode_control.sv
// Analog block and sync mode control registers with pin routing
`timescale 1ns/100ps
`include "abc_cfg.svh"
// Behaviour
// - Lockout bit clear selects low threshold
// - One amp disabled hands loop to other
// - Both amps disabled force outputs low
// - Voltage amp disable enables overvoltage protection
// - Current amp disable bit disables it
// - Digital enable connects digital mux to pin
// - Three-bit select picks digital test source
// - Analog enable connects analog mux to pin
// - Two-bit field selects sync mode
// - Master drives reference and sync clock
// - Slave uses external sync clock input
// - Stand-alone keeps reference off, clock internal
// - Semi-master option bit chooses pin routing
// - Unused mode bits ignore writes, read zero
// - All bits clear at reset
// - Digital wins when both enables set
// - Analog signals go to ADC while analog enable is clear
module analog_block_and_sync_mode_control
    import abc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [7:0] test_sources,
    input wire logic sync_clock_input,
    input wire logic sync_clock_internal,
    output amp_ctrl_t amp_ctrl,
    output pin_route_t route,
    output logic debug_dig_value,
    output logic debug_dig_drive,
    output logic debug_ana_drive,
    output logic analog_to_adc,
    output logic debug_gpio_own,
    output logic sync_clock_output,
    output logic pwm_clock
);
    logic [7:0] analog_block_enable_control;
    logic [7:0] sync_mode_control;
    sync_mode_t mode;
    logic semi_opt;
    logic m_bit, m_dd, m_ad, m_adc, m_gpio;
    amp_ctrl_t next_amp;
    pin_route_t next_route;
    logic next_clk;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            analog_block_enable_control <= `RST_ANALOG_CTRL;
        end else if (wr && addr == `ADDR_ANALOG_CTRL) begin
            analog_block_enable_control <= wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sync_mode_control <= `RST_SYNC_MODE;
        end else if (wr && addr == `ADDR_SYNC_MODE) begin
            sync_mode_control <= wdata & `SYNC_MODE_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata <= 8'h00;
        end else if (rd && addr == `ADDR_ANALOG_CTRL) begin
            rdata <= analog_block_enable_control;
        end else if (rd && addr == `ADDR_SYNC_MODE) begin
            rdata <= sync_mode_control;
        end else begin
            // Unmapped reads and idle cycles return zero
            rdata <= 8'h00;
        end
    end

    assign mode = sync_mode_t'(sync_mode_control[`BIT_MODE_HI:`BIT_MODE_LO]);
    assign semi_opt = sync_mode_control[`BIT_SEMI_OPT];

    test_mux u_mux (
        .sources(test_sources),
        .select(analog_block_enable_control[`BIT_DSEL_HI:`BIT_DSEL_LO]),
        .dig_en(analog_block_enable_control[`BIT_DIG_OE]),
        .ana_en(analog_block_enable_control[`BIT_ANA_OE]),
        .dig_bit(m_bit),
        .dig_drive(m_dd),
        .ana_drive(m_ad),
        .ana_to_adc(m_adc),
        .gpio_own(m_gpio)
    );

    always_comb begin
        logic vd;
        logic id;
        vd = analog_block_enable_control[`BIT_VAMP_DIS];
        id = analog_block_enable_control[`BIT_IAMP_DIS];
        next_amp.voltage_amp_on = ~vd;
        next_amp.current_amp_on = ~id;
        next_amp.voltage_in_control = ~vd;
        next_amp.current_in_control = ~id;
        next_amp.amps_forced_low = vd & id;
        next_amp.ov_protect_on = vd;
        next_amp.lockout_high = analog_block_enable_control[`BIT_LOCKOUT];
    end

    always_comb begin
        next_route = '0;
        next_clk = sync_clock_internal;
        case (mode)
            MODE_STANDALONE: begin
                next_route.internal_clock = 1'b1;
            end
            MODE_MASTER: begin
                next_route.reference_out_en = 1'b1;
                next_route.sync_out_en = 1'b1;
                next_route.internal_clock = 1'b1;
            end
            MODE_SLAVE: begin
                next_route.sync_in_use = 1'b1;
                next_clk = sync_clock_input;
            end
            MODE_SEMI: begin
                next_route.reference_out_en = ~semi_opt;
                next_route.sync_out_en = semi_opt;
                next_route.internal_clock = 1'b1;
            end
            default: begin
                next_route.internal_clock = 1'b1;
            end
        endcase
    end

    // Registered outputs add one cycle of lag to the sync clock; fine for slow PWM rates
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            amp_ctrl <= '0;
            route <= '0;
            pwm_clock <= 1'b0;
            sync_clock_output <= 1'b0;
        end else begin
            amp_ctrl <= next_amp;
            route <= next_route;
            pwm_clock <= next_clk;
            sync_clock_output <= next_route.sync_out_en & sync_clock_internal;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            debug_dig_value <= 1'b0;
            debug_dig_drive <= 1'b0;
            debug_ana_drive <= 1'b0;
            analog_to_adc <= 1'b0;
            debug_gpio_own <= 1'b0;
        end else begin
            debug_dig_value <= m_bit;
            debug_dig_drive <= m_dd;
            debug_ana_drive <= m_ad;
            analog_to_adc <= m_adc;
            debug_gpio_own <= m_gpio;
        end
    end

    logic [2:0] dsel_now;
    logic dig_oe_now;
    logic ana_oe_now;
    logic vdis_now;
    logic idis_now;
    assign dsel_now = analog_block_enable_control[`BIT_DSEL_HI:`BIT_DSEL_LO];
    assign dig_oe_now = analog_block_enable_control[`BIT_DIG_OE];
    assign ana_oe_now = analog_block_enable_control[`BIT_ANA_OE];
    assign vdis_now = analog_block_enable_control[`BIT_VAMP_DIS];
    assign idis_now = analog_block_enable_control[`BIT_IAMP_DIS];

    // Outputs still hold reset values one edge after release, so those edges are skipped
    a_lockout_follows: assert property (@(posedge clk_sys) disable iff (srst)
        wr && addr == `ADDR_ANALOG_CTRL ##2 1'b1 |->
            amp_ctrl.lockout_high == $past(wdata[`BIT_LOCKOUT], 2))
        else $error("lockout level wrong");

    a_lockout_level: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(srst) |->
            amp_ctrl.lockout_high == $past(analog_block_enable_control[`BIT_LOCKOUT]))
        else $error("lockout level stale");

    a_amp_handover: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(srst) && $past(vdis_now ^ idis_now) |->
            amp_ctrl.voltage_in_control != amp_ctrl.current_in_control
            && amp_ctrl.voltage_in_control == amp_ctrl.voltage_amp_on)
        else $error("disabled amp in control");

    a_both_low: assert property (@(posedge clk_sys) disable iff (srst)
        amp_ctrl.amps_forced_low |->
            !amp_ctrl.voltage_amp_on && !amp_ctrl.current_amp_on)
        else $error("amps not forced low");

    a_both_disabled: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(srst) && $past(vdis_now && idis_now) |->
            amp_ctrl.amps_forced_low && !amp_ctrl.voltage_in_control
            && !amp_ctrl.current_in_control)
        else $error("both disabled not low");

    a_ov_protect: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(srst) |->
            amp_ctrl.ov_protect_on == !amp_ctrl.voltage_amp_on)
        else $error("ov protection mismatch");

    a_voltage_amp: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(srst) |->
            amp_ctrl.voltage_amp_on == !$past(vdis_now))
        else $error("voltage amp enable wrong");

    a_current_amp: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(srst) |->
            amp_ctrl.current_amp_on == !$past(idis_now))
        else $error("current amp enable wrong");

    a_digital_drive: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(srst) |->
            debug_dig_drive == $past(dig_oe_now))
        else $error("digital drive wrong");

    a_digital_value: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(srst) && $past(dsel_now) != 3'h7 |->
            debug_dig_value == $past(test_sources[dsel_now]))
        else $error("digital source wrong");

    a_unused_select: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(srst) && $past(dsel_now) == 3'h7 |->
            !debug_dig_value)
        else $error("unused select not low");

    a_analog_drive: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(srst) |->
            debug_ana_drive == $past(ana_oe_now && !dig_oe_now))
        else $error("analog drive wrong");

    a_debug_priority: assert property (@(posedge clk_sys) disable iff (srst)
        debug_dig_drive |->
            !debug_ana_drive && !debug_gpio_own)
        else $error("debug pin contention");

    a_mode_internal: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(srst) |->
            route.internal_clock == ($past(mode) != MODE_SLAVE))
        else $error("clock source decode wrong");

    a_master_pins: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(srst) && $past(mode) == MODE_MASTER |->
            route.reference_out_en && route.sync_out_en && !route.sync_in_use)
        else $error("master routing wrong");

    a_master_clock: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(srst) && $past(mode) == MODE_MASTER |->
            sync_clock_output == $past(sync_clock_internal))
        else $error("master sync output wrong");

    a_slave_clock: assert property (@(posedge clk_sys) disable iff (srst)
        mode == MODE_SLAVE ##1 mode == MODE_SLAVE |->
            pwm_clock == $past(sync_clock_input))
        else $error("slave clock not external");

    a_slave_pins: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(srst) && $past(mode) == MODE_SLAVE |->
            route.sync_in_use && !route.sync_out_en && !sync_clock_output)
        else $error("slave routing wrong");

    a_standalone_pins: assert property (@(posedge clk_sys) disable iff (srst)
        $past(mode) == MODE_STANDALONE |->
            !route.reference_out_en && !route.sync_out_en)
        else $error("standalone routing wrong");

    a_standalone_clock: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(srst) && $past(mode) == MODE_STANDALONE |->
            route.internal_clock && pwm_clock == $past(sync_clock_internal))
        else $error("standalone clock wrong");

    a_semi_route: assert property (@(posedge clk_sys) disable iff (srst)
        $past(mode) == MODE_SEMI |->
            route.sync_out_en == $past(semi_opt)
            && route.reference_out_en != route.sync_out_en)
        else $error("semi master routing wrong");

    a_mode_unused: assert property (@(posedge clk_sys) disable iff (srst)
        1'b1 |->
            (sync_mode_control & ~`SYNC_MODE_MASK) == 8'h00)
        else $error("unused mode bits set");

    a_mode_readback: assert property (@(posedge clk_sys) disable iff (srst)
        rd && addr == `ADDR_SYNC_MODE |=>
            (rdata & ~`SYNC_MODE_MASK) == 8'h00)
        else $error("unused mode bits read");

    a_reset_clear: assert property (@(posedge clk_sys) disable iff (srst)
        $past(srst) |->
            analog_block_enable_control == `RST_ANALOG_CTRL
            && sync_mode_control == `RST_SYNC_MODE)
        else $error("registers not cleared");

    a_adc_path: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(srst) |->
            analog_to_adc == !$past(ana_oe_now))
        else $error("adc path wrong");

    a_gpio_own: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(srst) |->
            debug_gpio_own == !$past(dig_oe_now || ana_oe_now))
        else $error("debug pin ownership wrong");

    c_master: cover property (@(posedge clk_sys) route.reference_out_en && route.sync_out_en);
    c_slave: cover property (@(posedge clk_sys) route.sync_in_use);
    c_both_off: cover property (@(posedge clk_sys) amp_ctrl.amps_forced_low);
    c_both_test: cover property (@(posedge clk_sys) debug_dig_drive && !analog_to_adc);
    c_semi_sync: cover property (@(posedge clk_sys) route.sync_out_en && !route.reference_out_en);
endmodule : analog_block_and_sync_mode_control

// ===== design/test_mux.sv
// Digital test signal selector and debug pin arbitration
`timescale 1ns/100ps
`include "abc_cfg.svh"
module test_mux
    import abc_pkg::*;
(
    input wire logic [7:0] sources,
    input wire logic [2:0] select,
    input wire logic dig_en,
    input wire logic ana_en,
    output logic dig_bit,
    output logic dig_drive,
    output logic ana_drive,
    output logic ana_to_adc,
    output logic gpio_own
);
    always_comb begin
        // Code 111 has no source and reads low
        dig_bit = (select == 3'h7) ? 1'b0 : sources[select];
        dig_drive = dig_en;
        ana_drive = ana_en & ~dig_en;
        ana_to_adc = ~ana_en;
        gpio_own = ~dig_en & ~ana_en;
    end
endmodule : test_mux

// ===== sim/sync_master_model.sv
// External master that supplies the sync clock to a device in slave mode
`timescale 1ns/100ps
module sync_master_model (
    input wire logic clk_sys,
    input wire logic run,
    output logic sync_clk
);
    logic [1:0] cnt;
    initial begin
        cnt = 2'h0;
        sync_clk = 1'b0;
    end
    // Holds its level while stopped so the bench can compare a settled value
    always @(posedge clk_sys) begin
        if (run) begin
            cnt <= cnt + 2'h1;
            if (cnt == 2'h3) sync_clk <= ~sync_clk;
        end
    end
endmodule : sync_master_model

// ===== sim/test_analog_block_and_sync_mode_control.sv
// Register and pin routing tests for the analog block and sync mode control
`timescale 1ns/100ps
module test_analog_block_and_sync_mode_control
    import abc_pkg::*;
;
    logic clk_sys, srst, wr, rd, run, sync_clock_input, sync_clock_internal;
    logic debug_dig_value, debug_dig_drive, debug_ana_drive, analog_to_adc;
    logic debug_gpio_own, sync_clock_output, pwm_clock, l, v, i;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, test_sources;
    amp_ctrl_t amp_ctrl;
    pin_route_t route;
    int bad_count, checks;
    logic [3:0] en_exp [3] = '{4'h3, 4'h4, 4'ha};
    logic [3:0] rt_exp [8] = '{4'h1, 4'h1, 4'hd, 4'hd, 4'h2, 4'h2, 4'h9, 4'h5};
    analog_block_and_sync_mode_control analog_block_and_sync_mode_control_i (
        .clk_sys(clk_sys), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .test_sources(test_sources), .sync_clock_input(sync_clock_input),
        .sync_clock_internal(sync_clock_internal), .amp_ctrl(amp_ctrl), .route(route),
        .debug_dig_value(debug_dig_value), .debug_dig_drive(debug_dig_drive),
        .debug_ana_drive(debug_ana_drive), .analog_to_adc(analog_to_adc),
        .debug_gpio_own(debug_gpio_own), .sync_clock_output(sync_clock_output),
        .pwm_clock(pwm_clock)
    );
    sync_master_model sync_master_model_i (
        .clk_sys(clk_sys), .run(run), .sync_clk(sync_clock_input)
    );
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic results();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys) begin
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
        end
        @(posedge clk_sys) wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe, so look right then
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys) begin
            addr <= a;
            rd <= 1'b1;
        end
        @(posedge clk_sys) rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_reg
    initial begin
        #20000;
        bad_count++;
        $display("watchdog expired");
        results();
    end
    initial begin
        srst = 1'b1; wr = 1'b0; rd = 1'b0; run = 1'b0; addr = 4'h0; wdata = 8'h00;
        test_sources = 8'h00; sync_clock_internal = 1'b0;
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        tick(2);
        chk({1'b0, amp_ctrl}, 8'h78);
        chk({4'h0, route}, 8'h01);
        chk({6'h0, debug_gpio_own, analog_to_adc}, 8'h03);
        rd_reg(4'h0, 8'h00);
        rd_reg(4'h1, 8'h00);
        wr_reg(4'h2, 8'hff);
        rd_reg(4'h2, 8'h00);
        rd_reg(4'h1, 8'h00);
        for (int k = 0; k < 8; k++) begin
            {l, v, i} = k[2:0];
            wr_reg(4'h0, {4'h0, l, v, i, 1'b0});
            tick(2);
            chk({1'b0, amp_ctrl},
                {1'b0, ~v, ~i, ~v, ~i, v & i, v, l});
            rd_reg(4'h0, {4'h0, l, v, i, 1'b0});
        end
        // Both enables set, so every select also proves the digital side wins
        for (int s = 0; s < 8; s++) begin
            wr_reg(4'h0, {1'b1, s[2:0], 4'h1});
            test_sources <= 8'h01 << s;
            tick(2);
            chk({5'h0, debug_dig_value, debug_dig_drive, debug_ana_drive},
                {5'h0, s != 7, 2'h2});
            @(posedge clk_sys) test_sources <= ~(8'h01 << s);
            tick(2);
            chk({7'h0, debug_dig_value}, 8'h00);
        end
        for (int e = 0; e < 3; e++) begin
            wr_reg(4'h0, {e[1], 6'h0, e[0]});
            tick(2);
            chk({6'h0, debug_dig_drive, debug_ana_drive}, {6'h0, en_exp[e][3:2]});
            chk({6'h0, analog_to_adc, debug_gpio_own}, {6'h0, en_exp[e][1:0]});
        end
        for (int k = 0; k < 8; k++) begin
            @(posedge clk_sys) run <= 1'b1;
            wr_reg(4'h1, {k[2:1], 2'h3, k[0], 3'h7});
            tick(4);
            @(posedge clk_sys) run <= 1'b0;
            @(posedge clk_sys) sync_clock_internal <= ~sync_clock_input;
            tick(2);
            chk({4'h0, route}, {4'h0, rt_exp[k]});
            chk({7'h0, pwm_clock},
                {7'h0, k[2:1] == 2 ? sync_clock_input : sync_clock_internal});
            chk({7'h0, sync_clock_output},
                {7'h0, rt_exp[k][2] & sync_clock_internal});
            rd_reg(4'h1, {k[2:1], 2'h0, k[0], 3'h0});
        end
        // Reset again with both registers loaded, so the clear is really seen
        @(posedge clk_sys) srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        tick(2);
        chk({1'b0, amp_ctrl}, 8'h78);
        chk({4'h0, route}, 8'h01);
        rd_reg(4'h0, 8'h00);
        rd_reg(4'h1, 8'h00);
        results();
    end
endmodule : test_analog_block_and_sync_mode_control
